// ### design/sfw_consts.svh
// constants of the sampler writeback formatter: register map, field
// positions, reset values and layout counts
// assumes: included by bare name from every design file that needs it
// ************************************************************
// Functional notes
// ************************************************************
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH

// ************************************************************
// register map (byte addresses)
// ************************************************************
`define SFW_ADDR_CTRL   8'h00
`define SFW_ADDR_HDR    8'h04
`define SFW_ADDR_STAT   8'h08
`define SFW_ADDR_KMASK  8'h0C

// ************************************************************
// field positions
// ************************************************************
`define SFW_CTRL_TYPE_HI  3
`define SFW_CTRL_TYPE_LO  0
`define SFW_CTRL_HDRP     4
`define SFW_CTRL_DIEN     5
`define SFW_CTRL_DIPART   6
`define SFW_CTRL_GO       8
`define SFW_HDR_MASK_LO   12
`define SFW_HDR_OFFU_HI   11
`define SFW_HDR_OFFU_LO   8
`define SFW_HDR_OFFV_HI   7
`define SFW_HDR_OFFV_LO   4
`define SFW_HDR_OFFR_HI   3
`define SFW_HDR_OFFR_LO   0

// ************************************************************
// reset values and layout counts
// ************************************************************
`define SFW_CTRL_RST      9'h000
`define SFW_HDR_RST       32'h0000_0000
`define SFW_KMASK_RST     32'hFFFF_FFFF
`define SFW_UNORM_MAX     16'hFF00
`define SFW_UNORM_LAST    2'h1
`define SFW_BLOCK_LAST    2'h3
`define SFW_RG_KILL_REG   4'h4
`define SFW_LAST_DW       3'h7

`endif

// ### design/sfw_pkg.sv
// types shared by the sampler writeback formatter modules
// assumes: compiled before every module of the block
package sfw_pkg;

  // request kinds as held in the control register type field
  typedef enum logic [3:0] {
    SFW_SAMPLE,
    SFW_GATHER,
    SFW_GATHER_OFFU,
    SFW_UNORM,
    SFW_UNORM_RG,
    SFW_UNORM_KILL,
    SFW_UNORM_RG_KILL,
    SFW_BLOCK,
    SFW_DEINTERLACE
  } sfw_msg_type;

  typedef enum logic [1:0] {
    SFW_IDLE,
    SFW_COLOUR,
    SFW_MASKREG,
    SFW_LUMA
  } sfw_state_type;

endpackage : sfw_pkg

// ### design/sfw_hdr_dec.sv
// request header interpreter: channel enables and effective offsets
// assumes: header and type are stable while a writeback runs
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_hdr_dec (
  input  wire logic [31:0]        hdr,
  input  wire logic               hdr_present,
  input  wire sfw_pkg::sfw_msg_type msg,
  output logic      [3:0]         chan_en,
  output logic      [3:0]         off_u,
  output logic      [3:0]         off_v,
  output logic      [3:0]         off_r
);

  logic [31:0] h;
  logic        ign_all;
  logic        ign_uv;

  // absent header reads as zero: all channels on, no offsets
  assign h = hdr_present ? hdr : `SFW_HDR_RST;

  // bits 19:18 never looked at: colour output is always 16-bit full, luma output is bytes
  assign ign_all = (msg == sfw_pkg::SFW_UNORM)
                || (msg == sfw_pkg::SFW_UNORM_RG)
                || (msg == sfw_pkg::SFW_UNORM_KILL)
                || (msg == sfw_pkg::SFW_UNORM_RG_KILL)
                || (msg == sfw_pkg::SFW_BLOCK)
                || (msg == sfw_pkg::SFW_DEINTERLACE);
  assign ign_uv  = (msg == sfw_pkg::SFW_GATHER_OFFU);

  always_comb begin
    // red at bit 12 up to alpha at bit 15; a one drops it
    chan_en = ~h[`SFW_HDR_MASK_LO +: 4];
    if ((msg == sfw_pkg::SFW_UNORM_RG)
        || (msg == sfw_pkg::SFW_UNORM_RG_KILL)) begin
      chan_en[3:2] = 2'h0;
    end
    if (msg == sfw_pkg::SFW_DEINTERLACE) begin
      chan_en = 4'h1;
    end
  end

  // S3 fields sign-extended from bit 2; bit 3 is not trusted
  assign off_u = (ign_all || ign_uv) ? 4'h0 :
    {h[`SFW_HDR_OFFU_LO+2], h[`SFW_HDR_OFFU_LO +: 3]};
  assign off_v = (ign_all || ign_uv) ? 4'h0 :
    {h[`SFW_HDR_OFFV_LO+2], h[`SFW_HDR_OFFV_LO +: 3]};
  assign off_r = ign_all ? 4'h0 :
    {h[`SFW_HDR_OFFR_LO+2], h[`SFW_HDR_OFFR_LO +: 3]};

endmodule : sfw_hdr_dec

// ### design/sfw_pack.sv
// packs two adjacent 16-bit unorm pixels into one dword
// assumes: lo is the even pixel, hi the odd one
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_pack (
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  output logic      [31:0] dword
);

  // samples above 1.0 would alias into the next range; pin them
  function automatic logic [15:0] clamp(input logic [15:0] v);
    clamp = (v > `SFW_UNORM_MAX) ? `SFW_UNORM_MAX : v;
  endfunction : clamp

  assign dword = {clamp(hi), clamp(lo)};

endmodule : sfw_pack

// ### design/sfw_formatter.sv
// sampler writeback formatter top: APB registers, sample store,
// writeback sequencer
// assumes: samples and writeback sink run on MCLK; APB master on MCLK
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_formatter (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SMP_VALID,
  input  wire logic [1:0]  SMP_CHAN,
  input  wire logic [5:0]  SMP_PIX,
  input  wire logic [15:0] SMP_DATA,
  input  wire logic        SMP_KILL,
  output logic             WB_VALID,
  input  wire logic        WB_READY,
  output logic      [3:0]  WB_REG,
  output logic      [2:0]  WB_DWORD,
  output logic      [31:0] WB_DATA,
  output logic             WB_LAST,
  output logic      [3:0]  OFF_U,
  output logic      [3:0]  OFF_V,
  output logic      [3:0]  OFF_R,
  output logic             BUSY
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [15:0]           mem_q [0:255];
  logic [8:0]            ctrl_q;
  logic [31:0]           hdr_q;
  logic [31:0]           kmask_q;
  sfw_pkg::sfw_state_type state_q;
  logic [2:0]            chan_q;
  logic [1:0]            sub_q;
  logic [2:0]            dw_q;
  logic [3:0]            reg_q;
  logic                  blk_q;
  logic                  acc;
  logic                  commit;
  logic                  go;
  logic                  take;
  sfw_pkg::sfw_msg_type  msg;
  logic [3:0]            chan_en;
  logic [3:0]            off_u;
  logic [3:0]            off_v;
  logic [3:0]            off_r;
  logic                  is_kill;
  logic                  is_rg_kill;
  logic [1:0]            last_sub;
  logic                  last_blk;
  logic [3:0]            nxt;
  logic [3:0]            first;
  sfw_pkg::sfw_msg_type  go_msg;
  logic [3:0]            go_en;
  logic                  go_kill;
  logic                  go_none;
  logic [5:0]            pix;
  logic [31:0]           colour_dw;
  logic [31:0]           luma_dw;
  logic [31:0]           out_d;
  logic                  last_d;

  // ************************************************************
  // helpers
  // ************************************************************
  // next enabled channel at or above start; bit 3 flags none left
  function automatic logic [3:0] next_chan(input logic [3:0] en,
                                           input logic [2:0] start);
    next_chan = 4'h8;
    for (int c = 3; c >= 0; c--) begin
      if (en[c] && (c >= start)) begin
        next_chan = {2'h0, 2'(c)};
      end
    end
  endfunction : next_chan

  function automatic logic [7:0] luma_byte(input logic [15:0] v);
    luma_byte = v[15:8];
  endfunction : luma_byte

  // ************************************************************
  // APB slave
  // ************************************************************
  assign acc    = PSEL && PENABLE;
  assign commit = acc && PREADY && PWRITE;
  assign go     = commit && (PADDR == `SFW_ADDR_CTRL)
               && PWDATA[`SFW_CTRL_GO] && (state_q == sfw_pkg::SFW_IDLE);
  assign msg    = sfw_pkg::sfw_msg_type'(
                    ctrl_q[`SFW_CTRL_TYPE_HI:`SFW_CTRL_TYPE_LO]);
  assign go_msg = sfw_pkg::sfw_msg_type'(
                    PWDATA[`SFW_CTRL_TYPE_HI:`SFW_CTRL_TYPE_LO]);

  // one wait state: answer in the cycle after the first access cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (acc && !PREADY) begin
      PREADY  <= 1'b1;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PADDR == `SFW_ADDR_CTRL) begin
        PRDATA <= {23'h000000, ctrl_q};
      end else if (PADDR == `SFW_ADDR_HDR) begin
        PRDATA <= hdr_q;
      end else if (PADDR == `SFW_ADDR_STAT) begin
        PRDATA <= {24'h000000, 1'b0, reg_q, 2'(state_q), BUSY};
      end else if (PADDR == `SFW_ADDR_KMASK) begin
        PRDATA <= kmask_q;
      end else begin
        PSLVERR <= 1'b1;
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // setup writes refused while a writeback runs
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl_q <= `SFW_CTRL_RST;
      hdr_q  <= `SFW_HDR_RST;
    end else if (commit && (state_q == sfw_pkg::SFW_IDLE)) begin
      if (PADDR == `SFW_ADDR_CTRL) begin
        ctrl_q <= {1'b0, PWDATA[7:0]};
      end else if (PADDR == `SFW_ADDR_HDR) begin
        hdr_q <= PWDATA;
      end
    end
  end

  // ************************************************************
  // sample store and active-pixel mask
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (SMP_VALID) begin
      mem_q[{SMP_CHAN, SMP_PIX}] <= SMP_DATA;
    end
  end

  // kill reported with red sample; a write of ones re-arms pixels,
  // an arriving kill wins over that write
  always_ff @(posedge MCLK) begin
    if (RST) begin
      kmask_q <= `SFW_KMASK_RST;
    end else begin
      if (commit && (PADDR == `SFW_ADDR_KMASK)) begin
        kmask_q <= kmask_q | PWDATA;
      end
      if (SMP_VALID && (SMP_CHAN == 2'h0) && !SMP_PIX[5]) begin
        kmask_q[SMP_PIX[4:0]] <= !SMP_KILL;
      end
    end
  end

  // ************************************************************
  // header interpretation
  // ************************************************************
  sfw_hdr_dec u_hdr (
    .hdr         (hdr_q),
    .hdr_present (ctrl_q[`SFW_CTRL_HDRP]),
    .msg         (msg),
    .chan_en     (chan_en),
    .off_u       (off_u),
    .off_v       (off_v),
    .off_r       (off_r)
  );

  // a start decodes the control word being written, not the old one
  sfw_hdr_dec u_hdr_go (
    .hdr         (hdr_q),
    .hdr_present (PWDATA[`SFW_CTRL_HDRP]),
    .msg         (go_msg),
    .chan_en     (go_en),
    .off_u       (),
    .off_v       (),
    .off_r       ()
  );

  always_ff @(posedge MCLK) begin
    if (RST) begin
      OFF_U <= 4'h0;
      OFF_V <= 4'h0;
      OFF_R <= 4'h0;
    end else begin
      OFF_U <= off_u;
      OFF_V <= off_v;
      OFF_R <= off_r;
    end
  end

  // ************************************************************
  // writeback layout
  // ************************************************************
  assign is_rg_kill = (msg == sfw_pkg::SFW_UNORM_RG_KILL);
  assign is_kill    = is_rg_kill || (msg == sfw_pkg::SFW_UNORM_KILL);
  assign last_sub   = (msg == sfw_pkg::SFW_BLOCK) ? `SFW_BLOCK_LAST
                                                  : `SFW_UNORM_LAST;
  // two luma rows per register; full interlace removal gives two
  assign last_blk   = ctrl_q[`SFW_CTRL_DIEN]
                   && !ctrl_q[`SFW_CTRL_DIPART];
  assign nxt        = next_chan(chan_en, chan_q + 3'h1);
  assign first      = next_chan(go_en, 3'h0);
  assign go_kill    = (go_msg == sfw_pkg::SFW_UNORM_KILL)
                   || (go_msg == sfw_pkg::SFW_UNORM_RG_KILL);
  // all channels masked on a plain variant: nothing to send
  assign go_none    = first[3] && !go_kill
                   && (go_msg != sfw_pkg::SFW_DEINTERLACE);

  // row-major pixel numbering, sixteen per register
  assign pix = {sub_q, dw_q, 1'b0};

  sfw_pack u_pack (
    .lo    (mem_q[{chan_q[1:0], pix}]),
    .hi    (mem_q[{chan_q[1:0], pix | 6'h01}]),
    .dword (colour_dw)
  );

  // ascending x in ascending bytes; dwords 4..7 hold the odd row
  always_comb begin
    luma_dw = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      luma_dw[k*8 +: 8] = luma_byte(
        mem_q[{2'h0, blk_q, dw_q, 2'(k)}]);
    end
  end

  always_comb begin
    out_d  = colour_dw;
    last_d = 1'b0;
    case (state_q)
      sfw_pkg::SFW_COLOUR: begin
        last_d = (dw_q == `SFW_LAST_DW) && (sub_q == last_sub)
              && nxt[3] && !is_kill;
      end
      sfw_pkg::SFW_MASKREG: begin
        out_d  = kmask_q;
        last_d = 1'b1;
      end
      sfw_pkg::SFW_LUMA: begin
        out_d  = luma_dw;
        last_d = (dw_q == `SFW_LAST_DW) && (blk_q == last_blk);
      end
      default: begin
        out_d  = colour_dw;
        last_d = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // sequencer: one dword per cycle while the sink keeps up
  // ************************************************************
  assign take = (state_q != sfw_pkg::SFW_IDLE) && (!WB_VALID || WB_READY);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_q <= sfw_pkg::SFW_IDLE;
      chan_q  <= 3'h0;
      sub_q   <= 2'h0;
      dw_q    <= 3'h0;
      reg_q   <= 4'h0;
      blk_q   <= 1'b0;
    end else begin
      case (state_q)
        sfw_pkg::SFW_IDLE: begin
          if (go) begin
            sub_q <= 2'h0;
            dw_q  <= 3'h0;
            reg_q <= 4'h0;
            blk_q <= 1'b0;
            chan_q <= {1'b0, first[1:0]};
            if (go_msg == sfw_pkg::SFW_DEINTERLACE) begin
              state_q <= sfw_pkg::SFW_LUMA;
            end else if (!first[3]) begin
              state_q <= sfw_pkg::SFW_COLOUR;
            end else if (go_kill) begin
              state_q <= sfw_pkg::SFW_MASKREG;
            end
          end
        end
        sfw_pkg::SFW_COLOUR: begin
          if (take) begin
            dw_q <= dw_q + 3'h1;
            if (dw_q == `SFW_LAST_DW) begin
              reg_q <= reg_q + 4'h1;
              if (sub_q != last_sub) begin
                sub_q <= sub_q + 2'h1;
              end else if (!nxt[3]) begin
                sub_q  <= 2'h0;
                chan_q <= {1'b0, nxt[1:0]};
              end else if (is_kill) begin
                state_q <= sfw_pkg::SFW_MASKREG;
              end else begin
                state_q <= sfw_pkg::SFW_IDLE;
              end
            end
          end
        end
        sfw_pkg::SFW_MASKREG: begin
          if (take) begin
            state_q <= sfw_pkg::SFW_IDLE;
          end
        end
        sfw_pkg::SFW_LUMA: begin
          if (take) begin
            dw_q <= dw_q + 3'h1;
            if (dw_q == `SFW_LAST_DW) begin
              reg_q <= reg_q + 4'h1;
              blk_q <= 1'b1;
              if (blk_q == last_blk) begin
                state_q <= sfw_pkg::SFW_IDLE;
              end
            end
          end
        end
        default: begin
          state_q <= sfw_pkg::SFW_IDLE;
        end
      endcase
    end
  end

  // dwords 7:1 of the mask register are never emitted
  always_ff @(posedge MCLK) begin
    if (RST) begin
      WB_VALID <= 1'b0;
      WB_REG   <= 4'h0;
      WB_DWORD <= 3'h0;
      WB_DATA  <= 32'h0000_0000;
      WB_LAST  <= 1'b0;
    end else if (take) begin
      WB_VALID <= 1'b1;
      WB_DATA  <= out_d;
      WB_LAST  <= last_d;
      if (state_q == sfw_pkg::SFW_MASKREG) begin
        WB_DWORD <= 3'h0;
        WB_REG   <= is_rg_kill ? `SFW_RG_KILL_REG : reg_q;
      end else begin
        WB_DWORD <= dw_q;
        WB_REG   <= reg_q;
      end
    end else if (WB_READY) begin
      WB_VALID <= 1'b0;
      WB_LAST  <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= go || (state_q != sfw_pkg::SFW_IDLE) || (WB_VALID && !WB_READY)
           || take;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  AST_APB_ANSWER: assert property (acc && !PREADY |=> PREADY)
    else $error("apb access not answered next cycle");
  AST_WB_HOLD: assert property (WB_VALID && !WB_READY |=> WB_VALID
      && $stable(WB_DATA) && $stable(WB_REG) && $stable(WB_DWORD))
    else $error("writeback word changed while stalled");
  AST_MASKED_CHAN: assert property (
      state_q == sfw_pkg::SFW_COLOUR |-> chan_en[chan_q[1:0]])
    else $error("masked channel is being sent");
  AST_RG_ONLY: assert property (
      state_q == sfw_pkg::SFW_COLOUR
      && (msg == sfw_pkg::SFW_UNORM_RG || is_rg_kill)
      |-> chan_q < 3'h2)
    else $error("blue or alpha sent for two-channel variant");
  AST_RA_PAIR: assert property (
      take && state_q == sfw_pkg::SFW_COLOUR
      && msg == sfw_pkg::SFW_UNORM && chan_en == 4'h9 && chan_q == 3'h3
      |=> WB_REG == 4'h2 || WB_REG == 4'h3)
    else $error("alpha not at base plus two or three");
  AST_RG_KILL_IDX: assert property (
      WB_VALID && WB_LAST && is_rg_kill
      |-> WB_REG == 4'h4 && WB_DWORD == 3'h0)
    else $error("two-channel mask register misplaced");
  AST_CLAMP: assert property (
      take && state_q == sfw_pkg::SFW_COLOUR
      |=> WB_DATA[15:0] <= 16'hFF00 && WB_DATA[31:16] <= 16'hFF00)
    else $error("colour sample above one");
  AST_OFFS_IGNORED: assert property (
      BUSY && msg == sfw_pkg::SFW_BLOCK
      |=> OFF_U == 4'h0 && OFF_V == 4'h0 && OFF_R == 4'h0)
    else $error("offsets not ignored for block sample");
  AST_BLOCK_SPAN: assert property (
      take && state_q == sfw_pkg::SFW_COLOUR
      && msg == sfw_pkg::SFW_BLOCK && last_d
      |=> WB_REG == 4'($countones(chan_en) * 4 - 1))
    else $error("block sample does not end at its last register");
  AST_GO_RUNS: assert property (go && !go_none |=> BUSY ##1 WB_VALID)
    else $error("accepted start did not produce a word in two cycles");

  COV_RG_KILL: cover property (WB_VALID && WB_READY && WB_LAST
                               && is_rg_kill);
  COV_BLOCK: cover property (WB_VALID && WB_READY && WB_LAST
                             && msg == sfw_pkg::SFW_BLOCK);
  COV_LUMA: cover property (WB_VALID && WB_READY && WB_LAST
                            && msg == sfw_pkg::SFW_DEINTERLACE);
  COV_STALL: cover property (WB_VALID && !WB_READY ##1 WB_READY);

endmodule : sfw_formatter

// ### bench/sfw_sink.sv
// writeback sink standing in for the requesting thread's registers
// assumes: words arrive on the WB_* handshake in the MCLK domain
`timescale 1ns/1ps
module sfw_sink (
  input  wire logic        MCLK,
  input  wire logic        stall,
  input  wire logic        WB_VALID,
  output logic             WB_READY,
  input  wire logic [3:0]  WB_REG,
  input  wire logic [2:0]  WB_DWORD,
  input  wire logic [31:0] WB_DATA,
  input  wire logic        WB_LAST
);
  // ****************
  // register file
  // ****************
  logic [31:0] mem [0:127];
  int          n = 0;
  int          lw = 0;
  logic        ph = 1'b0;
  // stalled sink takes a word every other cycle, to test holding
  assign WB_READY = !stall || ph;
  always @(posedge MCLK) begin
    ph <= ~ph;
    if (WB_VALID && WB_READY) begin
      mem[{WB_REG, WB_DWORD}] <= WB_DATA;
      n <= n + 1;
      // position of the word flagged last, counted from one
      if (WB_LAST) begin
        lw <= n + 1;
      end
    end
  end
endmodule : sfw_sink

// ### bench/sampler_writeback_formatter_tb.sv
// self-checking bench for the writeback formatter
// assumes: design files and sfw_sink compiled first
`timescale 1ns/1ps
module sampler_writeback_formatter_tb;
  // ****************
  // signals
  // ****************
  logic        MCLK = 1'b0, RST = 1'b1, stall = 1'b0, er;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, SMP_VALID = 1'b0, SMP_KILL = 1'b0;
  logic [1:0]  SMP_CHAN = 2'h0;
  logic [5:0]  SMP_PIX = 6'h00;
  logic [15:0] SMP_DATA = 16'h0000;
  logic        WB_VALID, WB_READY, WB_LAST, BUSY;
  logic [3:0]  WB_REG, OFF_U, OFF_V, OFF_R;
  logic [2:0]  WB_DWORD;
  logic [31:0] WB_DATA;
  int          num_errors = 0, n_tests = 0, k, r, b, d, p;
  sfw_pkg::sfw_msg_type ot [7] = '{sfw_pkg::SFW_SAMPLE,
    sfw_pkg::SFW_GATHER, sfw_pkg::SFW_GATHER_OFFU, sfw_pkg::SFW_UNORM,
    sfw_pkg::SFW_BLOCK, sfw_pkg::SFW_DEINTERLACE, sfw_pkg::SFW_SAMPLE};
  logic [11:0] oe [7] = '{12'hD2F, 12'hD2F, 12'h00F, 12'h0, 12'h0,
    12'h0, 12'h0};

  always #25 MCLK = ~MCLK;

  sfw_formatter dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SMP_VALID(SMP_VALID), .SMP_CHAN(SMP_CHAN), .SMP_PIX(SMP_PIX),
    .SMP_DATA(SMP_DATA), .SMP_KILL(SMP_KILL), .WB_VALID(WB_VALID),
    .WB_READY(WB_READY), .WB_REG(WB_REG), .WB_DWORD(WB_DWORD),
    .WB_DATA(WB_DATA), .WB_LAST(WB_LAST), .OFF_U(OFF_U),
    .OFF_V(OFF_V), .OFF_R(OFF_R), .BUSY(BUSY));
  sfw_sink snk (.MCLK(MCLK), .stall(stall), .WB_VALID(WB_VALID),
    .WB_READY(WB_READY), .WB_REG(WB_REG), .WB_DWORD(WB_DWORD),
    .WB_DATA(WB_DATA), .WB_LAST(WB_LAST));

  // ****************
  // tasks
  // ****************
  function automatic logic [15:0] sv(input int c, input int q);
    return {c[1:0], q[5:0], 8'h00};
  endfunction : sv

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic setup(input sfw_pkg::sfw_msg_type t, input logic [2:0] f,
                       input logic [31:0] h, input logic go);
    apb(1'b1, 8'h04, h);
    apb(1'b1, 8'h00, {23'h0, go, 1'b0, f, t});
  endtask : setup

  task automatic run(input sfw_pkg::sfw_msg_type t, input logic [2:0] f,
                     input logic [31:0] h);
    for (int i = 0; i < 128; i++) snk.mem[i] = 32'hDEAD_BEEF;
    snk.n = 0;
    snk.lw = 0;
    r = 0;
    setup(t, f, h, 1'b1);
    repeat (3) @(posedge MCLK);
    while (BUSY !== 1'b0) @(posedge MCLK);
    @(posedge MCLK);
    chk(snk.lw, snk.n);
  endtask : run

  // channels in R,G,B,A order, masked ones closed up
  task automatic chk_col(input logic [3:0] en, input int per);
    for (int c = 0; c < 4; c++)
      if (en[c])
        for (int j = 0; j < per; j++) begin
          for (int w = 0; w < 8; w++) begin
            p = j * 16 + 2 * w;
            chk(snk.mem[r*8+w], {sv(c, p + 1), sv(c, p)});
          end
          r++;
        end
  endtask : chk_col

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge MCLK);
    num_errors++;
    end_of_test();
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    // red pixel 5 killed; alpha pixel 63 hits full scale
    for (k = 0; k < 256; k++) begin
      SMP_VALID <= 1'b1;
      SMP_CHAN <= k[7:6];
      SMP_PIX <= k[5:0];
      SMP_DATA <= sv(k / 64, k);
      SMP_KILL <= (k == 5);
      @(posedge MCLK);
    end
    SMP_VALID <= 1'b0;
    SMP_KILL <= 1'b0;
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'hFFFF_FFDF);
    for (k = 0; k < 7; k++) begin
      setup(ot[k], (k == 6) ? 3'h0 : 3'h1, 32'h0000_0527, 1'b0);
      repeat (2) @(posedge MCLK);
      chk({20'h0, OFF_U, OFF_V, OFF_R}, {20'h0, oe[k]});
    end
    run(sfw_pkg::SFW_UNORM, 3'h1, 32'h000C_6527);
    chk_col(4'b1001, 2);
    chk(snk.n, 32);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_0020);
    run(sfw_pkg::SFW_UNORM_KILL, 3'h1, 32'h0000_2000);
    chk_col(4'b1101, 2);
    chk(snk.mem[r*8], 32'hFFFF_FFDF);
    chk(snk.mem[r*8+1], 32'hDEAD_BEEF);
    chk(snk.n, 49);
    run(sfw_pkg::SFW_UNORM_RG_KILL, 3'h0, 32'h0000_F000);
    chk_col(4'b0011, 2);
    chk(snk.mem[32], 32'hFFFF_FFDF);
    chk(snk.n, 33);
    // red and green masked: only the mask word comes back
    run(sfw_pkg::SFW_UNORM_RG_KILL, 3'h1, 32'h0000_3000);
    chk(snk.mem[32], 32'hFFFF_FFDF);
    chk(snk.n, 1);
    stall <= 1'b1;
    run(sfw_pkg::SFW_BLOCK, 3'h1, 32'h0000_1527);
    stall <= 1'b0;
    chk_col(4'b1110, 4);
    chk(snk.n, 96);
    for (b = 1; b < 3; b++) begin
      run(sfw_pkg::SFW_DEINTERLACE, (b == 1) ? 3'h7 : 3'h3, 32'h0000_F000);
      chk(snk.n, b * 8);
      for (k = 0; k < b * 8; k++) begin
        p = k * 4;
        chk(snk.mem[k], {2'b0, 6'(p + 3), 2'b0, 6'(p + 2), 2'b0,
                         6'(p + 1), 2'b0, 6'(p)});
      end
    end
    // a red sample above full scale must come back pinned
    SMP_VALID <= 1'b1;
    SMP_CHAN <= 2'h0;
    SMP_PIX <= 6'h00;
    SMP_DATA <= 16'hFFFF;
    @(posedge MCLK);
    SMP_VALID <= 1'b0;
    run(sfw_pkg::SFW_UNORM, 3'h1, 32'h0000_E000);
    chk(snk.mem[0], {sv(0, 1), 16'hFF00});
    end_of_test();
  end
endmodule : sampler_writeback_formatter_tb
